/* src/iox_core.sv */
// I2C target I/O expander core with change alert and 16 port pins
`timescale 1ns/1ps
`include "iox_consts.svh"

module iox_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_sel_bit0,
  input wire logic addr_sel_bit1,
  input wire logic addr_sel_bit2,
  input wire logic [15:0] port_in,
  output logic [15:0] port_out,
  output logic [15:0] port_oe,
  output logic alert_n_out,
  output logic alert_n_oe
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  iox_pkg::iox_pins_t pins_raw;
  iox_pkg::iox_pins_t pins;

  // Gather pins into one carrier so they share one synchroniser
  assign pins_raw.scl = scl_in;
  assign pins_raw.sda = sda_in;
  assign pins_raw.addr_sel = {addr_sel_bit2, addr_sel_bit1, addr_sel_bit0};
  assign pins_raw.port = port_in;

  iox_sync #(
    .WIDTH($bits(iox_pkg::iox_pins_t)),
    .RESET_VAL({$bits(iox_pkg::iox_pins_t){1'b1}})
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(pins_raw),
    .q(pins)
  );

  // ----------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------
  logic scl_prev;
  logic sda_prev;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // Previous filtered levels for edge finding
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_prev <= pins.scl;
      sda_prev <= pins.sda;
    end
  end

  // SDA moving while SCL stays high marks Start or Stop
  assign scl_rise = pins.scl & ~scl_prev;
  assign scl_fall = ~pins.scl & scl_prev;
  assign bus_start = pins.scl & scl_prev & sda_prev & ~pins.sda;
  assign bus_stop = pins.scl & scl_prev & ~sda_prev & pins.sda;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] out_reg [2];
  logic [7:0] pol_reg [2];
  logic [7:0] cfg_reg [2];
  logic [7:0] cap_reg [2];
  logic [2:0] reg_ptr;
  logic rx_stb;
  logic rx_is_cmd;
  logic [7:0] rx_byte;
  logic rd_ack_stb;
  logic cap_loaded;

  // Read value of any register; input ports show live pins with polarity applied
  function automatic logic [7:0] read_reg(
    input logic [2:0] idx,
    input logic [15:0] pin_lvl,
    input logic [7:0] o0,
    input logic [7:0] o1,
    input logic [7:0] p0,
    input logic [7:0] p1,
    input logic [7:0] c0,
    input logic [7:0] c1
  );
    logic [7:0] val;
    val = 8'h00;
    case (idx)
      `IOX_REG_IN0: val = pin_lvl[7:0] ^ p0;
      `IOX_REG_IN1: val = pin_lvl[15:8] ^ p1;
      `IOX_REG_OUT0: val = o0;
      `IOX_REG_OUT1: val = o1;
      `IOX_REG_POL0: val = p0;
      `IOX_REG_POL1: val = p1;
      `IOX_REG_CFG0: val = c0;
      `IOX_REG_CFG1: val = c1;
      default: val = 8'h00;
    endcase
    return val;
  endfunction

  // Select byte sets the pointer; data bytes land in the pointer then flip within the pair
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_ptr <= `IOX_REG_IN0;
      out_reg[0] <= `IOX_RST_OUT;
      out_reg[1] <= `IOX_RST_OUT;
      pol_reg[0] <= `IOX_RST_POL;
      pol_reg[1] <= `IOX_RST_POL;
      cfg_reg[0] <= `IOX_RST_CFG;
      cfg_reg[1] <= `IOX_RST_CFG;
    end
    else if (rx_stb)
    begin
      if (rx_is_cmd)
        reg_ptr <= rx_byte[2:0];
      else
      begin
        case (reg_ptr)
          `IOX_REG_OUT0: out_reg[0] <= rx_byte;
          `IOX_REG_OUT1: out_reg[1] <= rx_byte;
          `IOX_REG_POL0: pol_reg[0] <= rx_byte;
          `IOX_REG_POL1: pol_reg[1] <= rx_byte;
          `IOX_REG_CFG0: cfg_reg[0] <= rx_byte;
          `IOX_REG_CFG1: cfg_reg[1] <= rx_byte;
          default: ; // Input ports ignore writes
        endcase
        reg_ptr <= {reg_ptr[2:1], ~reg_ptr[0]};
      end
    end
  end

  // Captured input values; loaded once after reset release, then at each input-port read ack
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cap_reg[0] <= 8'h00;
      cap_reg[1] <= 8'h00;
      cap_loaded <= 1'b0;
    end
    else if (!cap_loaded)
    begin
      cap_reg[0] <= pins.port[7:0];
      cap_reg[1] <= pins.port[15:8];
      cap_loaded <= 1'b1;
    end
    else if (rd_ack_stb)
    begin
      // Only the port that was read is recaptured
      if (reg_ptr == `IOX_REG_IN0)
        cap_reg[0] <= pins.port[7:0];
      if (reg_ptr == `IOX_REG_IN1)
        cap_reg[1] <= pins.port[15:8];
    end
  end

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  iox_pkg::iox_state_t state;
  logic [7:0] next_tx;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic rw_read;
  logic first_rx;
  logic [2:0] sel_latched;

  // Byte to send next; one decode shared by the ack and the master-ack paths
  assign next_tx = read_reg(reg_ptr, pins.port, out_reg[0], out_reg[1],
                            pol_reg[0], pol_reg[1], cfg_reg[0], cfg_reg[1]);

  // Serial engine; Start and Stop override any state
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= iox_pkg::IOX_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      rw_read <= 1'b0;
      first_rx <= 1'b0;
      sel_latched <= 3'h0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      rx_stb <= 1'b0;
      rx_is_cmd <= 1'b0;
      rx_byte <= 8'h00;
      rd_ack_stb <= 1'b0;
    end
    else
    begin
      rx_stb <= 1'b0;
      rd_ack_stb <= 1'b0;
      sda_out <= 1'b0;
      if (bus_start)
      begin
        // Repeated Start also lands here; select pins frozen for the transfer
        state <= iox_pkg::IOX_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
        sel_latched <= pins.addr_sel;
      end
      else if (bus_stop)
      begin
        state <= iox_pkg::IOX_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        case (state)
          iox_pkg::IOX_IDLE:
            sda_oe <= 1'b0;
          iox_pkg::IOX_ADDR, iox_pkg::IOX_RX:
          begin
            if (scl_rise && bit_cnt != `IOX_BITS_PER_BYTE)
            begin
              shift <= {shift[6:0], pins.sda};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == `IOX_BITS_PER_BYTE)
            begin
              bit_cnt <= 4'h0;
              if (state == iox_pkg::IOX_ADDR)
              begin
                // General call (all zero) never matches the fixed high bits
                if (shift[7:1] == {`IOX_ADDR_HI, sel_latched})
                begin
                  rw_read <= shift[0];
                  first_rx <= ~shift[0];
                  sda_oe <= 1'b1;
                  state <= iox_pkg::IOX_ACK;
                end
                else
                  state <= iox_pkg::IOX_IDLE;
              end
              else
              begin
                rx_stb <= 1'b1;
                rx_is_cmd <= first_rx;
                rx_byte <= shift;
                first_rx <= 1'b0;
                sda_oe <= 1'b1;
                state <= iox_pkg::IOX_ACK;
              end
            end
          end
          iox_pkg::IOX_ACK:
          begin
            // Hold SDA low until the ack clock falls, then release or send
            if (scl_fall)
            begin
              if (rw_read)
              begin
                shift <= next_tx;
                sda_oe <= ~next_tx[7];
                bit_cnt <= 4'h0;
                state <= iox_pkg::IOX_TX;
              end
              else
              begin
                sda_oe <= 1'b0;
                state <= iox_pkg::IOX_RX;
              end
            end
          end
          iox_pkg::IOX_TX:
          begin
            if (scl_fall)
            begin
              if (bit_cnt == `IOX_LAST_BIT)
              begin
                sda_oe <= 1'b0;
                state <= iox_pkg::IOX_TXACK;
              end
              else
              begin
                // Open-drain: a 1 bit is sent by releasing the line
                sda_oe <= ~shift[6];
                shift <= {shift[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          iox_pkg::IOX_TXACK:
          begin
            // A pin change in this very cycle is absorbed by the recapture
            if (scl_rise)
            begin
              rd_ack_stb <= 1'b1;
              rw_read <= ~pins.sda;
            end
            else if (scl_fall)
            begin
              if (rw_read)
              begin
                shift <= next_tx;
                sda_oe <= ~next_tx[7];
                bit_cnt <= 4'h0;
                state <= iox_pkg::IOX_TX;
              end
              else
              begin
                sda_oe <= 1'b0;
                state <= iox_pkg::IOX_IDLE;
              end
            end
          end
          default:
          begin
            sda_oe <= 1'b0;
            state <= iox_pkg::IOX_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Port drivers and change alert
  // ----------------------------------------------------------------
  logic [15:0] in_mode;
  logic [15:0] cap_all;
  logic change_seen;

  // Configuration bit 1 means input with drivers off
  assign in_mode = {cfg_reg[1], cfg_reg[0]};
  assign cap_all = {cap_reg[1], cap_reg[0]};
  // Live compare, so a return to the captured level clears with no extra state
  assign change_seen = |((pins.port ^ cap_all) & in_mode);

  // Registered pin drivers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      port_out <= {`IOX_RST_OUT, `IOX_RST_OUT};
      port_oe <= 16'h0000;
    end
    else
    begin
      port_out <= {out_reg[1], out_reg[0]};
      port_oe <= ~in_mode;
    end
  end

  // Open-drain alert: data is always low, only the enable moves
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      alert_n_out <= 1'b0;
      alert_n_oe <= 1'b0;
    end
    else
    begin
      alert_n_out <= 1'b0;
      alert_n_oe <= change_seen & cap_loaded;
    end
  end

endmodule

/* pkg/iox_consts.svh */
// Constants of the I/O expander core: addresses, register indices, reset values
`ifndef IOX_CONSTS_SVH
`define IOX_CONSTS_SVH

// Fixed upper four bits of the 7-bit target address
`define IOX_ADDR_HI 4'h4
// Register indices carried by the register-select byte
`define IOX_REG_IN0 3'h0
`define IOX_REG_IN1 3'h1
`define IOX_REG_OUT0 3'h2
`define IOX_REG_OUT1 3'h3
`define IOX_REG_POL0 3'h4
`define IOX_REG_POL1 3'h5
`define IOX_REG_CFG0 3'h6
`define IOX_REG_CFG1 3'h7
// Power-up defaults of the writable registers
`define IOX_RST_OUT 8'hFF
`define IOX_RST_POL 8'h00
`define IOX_RST_CFG 8'hFF
// Bits in a byte and last bit index
`define IOX_BITS_PER_BYTE 4'h8
`define IOX_LAST_BIT 4'h7

`endif

/* pkg/iox_pkg.sv */
// Types shared by the I/O expander core
package iox_pkg;

  // Everything that arrives from the pins, kept together through the synchroniser
  typedef struct packed {
    logic scl;
    logic sda;
    logic [2:0] addr_sel;
    logic [15:0] port;
  } iox_pins_t;

  // Bus transfer states
  typedef enum logic [2:0] {
    IOX_IDLE,
    IOX_ADDR,
    IOX_ACK,
    IOX_RX,
    IOX_TX,
    IOX_TXACK
  } iox_state_t;

endpackage

/* src/iox_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module iox_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Shift chain; stage1 is read only by stage2
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
    end
    else
    begin
      stage1 <= d;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A bit changes only once the two later stages agree, which rejects short glitches
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      q <= RESET_VAL;
    else
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (stage2[i] == stage3[i])
          q[i] <= stage3[i];
      end
    end
  end

endmodule

/* sim/iox_i2c_master.sv */
// Bus master model that frames transfers toward the expander
`timescale 1ns/1ps

module iox_i2c_master #(
  parameter int QTR = 250
) (
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  // --------------------------------
  // Frame and bit helpers
  // --------------------------------
  // Idle bus: both lines released, SCL stands still between frames
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // Start from an idle bus, then park SCL low
  task automatic start();
    sda_rel = 1'b0;
    #(2 * QTR);
    scl = 1'b0;
  endtask

  // Data moves only in the low phase; sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    #(QTR);
    sda_rel = b;
    #(QTR);
    scl = 1'b1;
    #(2 * QTR);
    r = sda;
    scl = 1'b0;
  endtask

  // Byte MSB first, then the acknowledge slot; mack high leaves SDA released
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(mack, ack);
  endtask

  // Stop returns the bus to idle before anything new starts
  task automatic stop();
    #(QTR);
    sda_rel = 1'b0;
    #(QTR);
    scl = 1'b1;
    #(2 * QTR);
    sda_rel = 1'b1;
    #(4 * QTR);
  endtask
endmodule

/* sim/iox_core_assertions.sv */
// Concurrent checks on the expander core ports
`timescale 1ns/1ps

module iox_core_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [15:0] port_in,
  input wire logic [15:0] port_out,
  input wire logic [15:0] port_oe,
  input wire logic alert_n_out,
  input wire logic alert_n_oe
);
  // --------------------------------
  // Helpers and properties
  // --------------------------------
  // Alert latency of 4 us at 40 MHz; settle window covers sync plus compare
  localparam int ALERT_MAX = 160;
  localparam int SETTLE = 20;
  logic [15:0] prev_in;
  logic [15:0] prev_oe;
  logic [5:0] quiet;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Previous input-mode levels and directions
  always_ff @(posedge clk)
  begin
    prev_in <= port_in & ~port_oe;
    prev_oe <= port_oe;
  end

  // Age of the last move; saturates so it never wraps back into the window
  always_ff @(posedge clk)
  begin
    if (!rst_n || prev_in != (port_in & ~port_oe) || prev_oe != port_oe)
      quiet <= 6'h00;
    else if (quiet != 6'h3F)
      quiet <= quiet + 6'h01;
  end

  sequence s_ack_hold;
    sda_oe [*8];
  endsequence

  a_reset_dflt: assert property (
    disable iff (1'b0) !rst_n ##1 !rst_n |=> port_oe == 16'h0000 && port_out == 16'hFFFF && !sda_oe && !alert_n_oe)
    else $error("outputs not at defaults after reset");
  a_alert_cause: assert property (
    $rose(alert_n_oe) |-> quiet < SETTLE || $changed(port_oe))
    else $error("alert rose with no input or direction change");
  a_alert_fast: assert property (
    !alert_n_oe && $changed(port_in & ~port_oe) && $stable(port_oe) |-> ##[1:ALERT_MAX] alert_n_oe)
    else $error("input change not alerted in time");
  a_alert_clear: assert property (
    $fell(alert_n_oe) |-> scl_in || quiet < SETTLE)
    else $error("alert cleared outside ack pulse or pin return");
  a_sda_low_move: assert property (
    $changed(sda_oe) |-> !scl_in)
    else $error("sda drive moved while scl high");
  a_ack_hold: assert property (
    $rose(scl_in) && sda_oe |-> s_ack_hold)
    else $error("sda drive dropped in high phase");
  a_out_latch: assert property (
    $changed(port_out) |-> !scl_in)
    else $error("output latch moved while scl high");
  a_dir_latch: assert property (
    $changed(port_oe) |-> !scl_in)
    else $error("direction moved while scl high");
  a_alert_pull: assert property (
    !alert_n_out)
    else $error("alert line driven high");
  a_sda_pull: assert property (
    !sda_out)
    else $error("sda driven high");
endmodule

bind iox_core iox_core_assertions u_chk (
  .clk(clk),
  .rst_n(rst_n),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .port_in(port_in),
  .port_out(port_out),
  .port_oe(port_oe),
  .alert_n_out(alert_n_out),
  .alert_n_oe(alert_n_oe)
);

/* sim/iox_core_tb_top.sv */
// Self-checking bench for the expander core
`timescale 1ns/1ps

module iox_core_tb_top;
  logic clk;
  logic rst_n;
  logic [15:0] port_in;
  logic [2:0] sel;
  logic scl;
  logic sda_rel;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic [15:0] port_out;
  logic [15:0] port_oe;
  logic alert_n_out;
  logic alert_n_oe;
  logic nak;
  logic [7:0] rb;
  int err_total;
  int checks;

  // --------------------------------
  // Harness
  // --------------------------------
  // Pulled-up data wire, low while either party pulls
  assign sda = sda_rel & ~(sda_oe & ~sda_out);

  always #12.5 clk = ~clk;

  iox_i2c_master #(.QTR(250)) bfm (.scl(scl), .sda_rel(sda_rel), .sda(sda));

  iox_core dut (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_sel_bit0(sel[0]), .addr_sel_bit1(sel[1]), .addr_sel_bit2(sel[2]), .port_in(port_in),
    .port_out(port_out), .port_oe(port_oe), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic pin(input logic [15:0] v);
    @(posedge clk);
    #2;
    port_in = v;
  endtask

  // Bounded wait of 4 us for the alert level
  task automatic wait_al(input logic e);
    for (int i = 0; i < 160 && alert_n_oe !== e; i++)
    begin
      @(posedge clk);
    end
    chk({15'h0000, alert_n_oe}, {15'h0000, e});
  endtask

  task automatic hold_al(input logic e);
    repeat (200) @(posedge clk);
    chk({15'h0000, alert_n_oe}, {15'h0000, e});
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d[$]);
    logic [7:0] x;
    logic k;
    bfm.start();
    bfm.xfer({a, 1'b0}, 1'b1, x, nak);
    foreach (d[i])
    begin
      if (nak === 1'b0)
        bfm.xfer(d[i], 1'b1, x, k);
    end
    bfm.stop();
  endtask

  // Reads n bytes, acking all but the last, each compared with e
  task automatic rd(input logic [6:0] a, input int n, input logic [7:0] e);
    logic k;
    bfm.start();
    bfm.xfer({a, 1'b1}, 1'b1, rb, nak);
    for (int i = 0; i < n && nak === 1'b0; i++)
    begin
      bfm.xfer(8'hFF, i == n - 1, rb, k);
      chk({8'h00, rb}, {8'h00, e});
    end
    bfm.stop();
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  // Address select pins never move during the run
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    port_in = 16'hFFFF;
    sel = 3'h5;
    err_total = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (12) @(posedge clk);
    chk(port_oe, 16'h0000);
    chk(port_out, 16'hFFFF);
    hold_al(1'b0);
    wr(7'h24, {8'h06});
    chk({15'h0000, nak}, 16'h0001);
    wr(7'h00, {8'h06});
    chk({15'h0000, nak}, 16'h0001);
    wr(7'h25, {8'h06, 8'h0F, 8'hFF});
    chk({15'h0000, nak}, 16'h0000);
    chk(port_oe, 16'h00F0);
    wr(7'h25, {8'h03, 8'h11, 8'h22, 8'h33});
    chk(port_out, 16'h3322);
    wr(7'h25, {8'h06});
    rd(7'h25, 2, 8'h0F);
    pin(16'hFF7F);
    hold_al(1'b0);
    pin(16'hFF7E);
    wait_al(1'b1);
    pin(16'hFF7F);
    wait_al(1'b0);
    pin(16'hFE7E);
    wait_al(1'b1);
    wr(7'h25, {8'h00, 8'h55});
    rd(7'h25, 1, 8'hFE);
    hold_al(1'b1);
    wr(7'h25, {8'h00});
    rd(7'h25, 1, 8'h7E);
    wait_al(1'b0);
    pin(16'hFEFE);
    hold_al(1'b0);
    pin(16'hFEFF);
    wait_al(1'b1);
    rd(7'h25, 1, 8'hFF);
    wait_al(1'b0);
    pin(16'hFE7F);
    hold_al(1'b0);
    wr(7'h25, {8'h06, 8'hFF});
    wait_al(1'b1);
    rd(7'h26, 1, 8'h00);
    chk({15'h0000, nak}, 16'h0001);
    hold_al(1'b1);
    @(posedge clk);
    #2;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    chk(port_oe, 16'h0000);
    chk(port_out, 16'hFFFF);
    #2;
    rst_n = 1'b1;
    repeat (12) @(posedge clk);
    wr(7'h25, {8'h00});
    rd(7'h25, 1, 8'h7F);
    end_sim();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #(2_000_000);
    err_total++;
    end_sim();
  end
endmodule
